// [design/reboot_flash_ctrl.sv]
/*
 * Register bank and sequencer of the self-reprogramming controller:
 * classic Wishbone slave, flash byte transfers, configuration port
 * readback and reprogram sequences.
 * Assumes one system clock; the config port answers on that clock.
 */
`timescale 1ns/1ps
module reboot_flash_ctrl #(
    parameter logic [15:0] SYNC_WORD_HI = 16'h1234,
    parameter logic [15:0] SYNC_WORD_LO = 16'h5678,
    parameter logic [15:0] NOOP_WORD = 16'h0001,
    parameter logic [15:0] HDR_READ_BASE = 16'h0003,
    parameter int unsigned HDR_ADDR_SHIFT = 5,
    parameter logic [15:0] HDR_CMD_WRITE = 16'h0005,
    parameter logic [15:0] CMD_DESYNC = 16'h0007,
    parameter logic [15:0] CMD_REPROG = 16'h0009,
    parameter int unsigned CAP_W = 16,
    parameter int unsigned READ_WAIT = reboot_pkg::CAP_READ_WAIT_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Flash pins
    output logic flash_sclk,
    output logic flash_mosi,
    output logic flash_cs_n,
    input wire logic flash_miso,
    // Configuration access port
    output logic cap_en,
    output logic cap_write,
    output logic [15:0] cap_wdata,
    input wire logic [CAP_W-1:0] cap_rdata
);
    import reboot_pkg::*;

    if (CAP_W < IMG_VALUE_W) begin : g_cap_check
        $error("CAP_W must be at least 16");
    end
    if (READ_WAIT < 1 || READ_WAIT > 8) begin : g_wait_check
        $error("READ_WAIT must be 1 to 8");
    end
    if (HDR_ADDR_SHIFT > 10) begin : g_shift_check
        $error("HDR_ADDR_SHIFT must leave the address inside 16 bits");
    end

    typedef struct packed {
        seq_state_e state;
        seq_kind_e kind;
        logic [2:0] step;
        logic [2:0] wait_cnt;
        logic [1:0] byte_idx;
        logic spi_start;
        logic ack;
        logic [31:0] rdata;
        logic trig;
        logic unlock;
        logic start;
        logic [CTL_ADDR_W-1:0] cfg_addr;
        logic [IMG_VALUE_W-1:0] image;
        logic valid;
        logic [31:0] golden;
        logic [31:0] update;
        logic [FA_DATA_W-1:0] fdata;
        logic [1:0] fcount;
        logic fcs;
        logic fgo;
        logic fready;
        logic cap_en;
        logic cap_write;
        logic [15:0] cap_wdata;
    } ctrl_s;

    ctrl_s cur_reg;
    ctrl_s cur_next;

    spi_byte_if spi_bus ();

    // Byte lane merge for partial writes
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Port word for a step of a sequence; bit 16 marks the last word
    function automatic logic [16:0] seq_word(input seq_kind_e kind,
                                             input logic [2:0] step,
                                             input logic [CTL_ADDR_W-1:0] addr);
        logic [15:0] rd_hdr;
        logic [16:0] res;
        rd_hdr = HDR_READ_BASE | 16'({10'h000, addr} << HDR_ADDR_SHIFT);
        res = {1'b1, NOOP_WORD};
        unique case (kind)
            KIND_RB_PRE: begin
                unique case (step)
                    3'h0: res = {1'b0, SYNC_WORD_HI};
                    3'h1: res = {1'b0, SYNC_WORD_LO};
                    3'h2: res = {1'b0, NOOP_WORD};
                    3'h3: res = {1'b0, rd_hdr};
                    3'h4: res = {1'b0, NOOP_WORD};
                    default: res = {1'b1, NOOP_WORD};
                endcase
            end
            KIND_RB_POST: begin
                unique case (step)
                    3'h0: res = {1'b0, HDR_CMD_WRITE};
                    3'h1: res = {1'b0, CMD_DESYNC};
                    3'h2: res = {1'b0, NOOP_WORD};
                    default: res = {1'b1, NOOP_WORD};
                endcase
            end
            KIND_PROG: begin
                unique case (step)
                    3'h0: res = {1'b0, SYNC_WORD_HI};
                    3'h1: res = {1'b0, SYNC_WORD_LO};
                    3'h2: res = {1'b0, NOOP_WORD};
                    3'h3: res = {1'b0, HDR_CMD_WRITE};
                    3'h4: res = {1'b0, CMD_REPROG};
                    default: res = {1'b1, NOOP_WORD};
                endcase
            end
            default: res = {1'b1, NOOP_WORD};
        endcase
        return res;
    endfunction

    logic [31:0] control_view;
    logic [31:0] image_view;
    logic [31:0] flash_view;
    logic [31:0] read_mux;
    logic [31:0] wr_control;
    logic [31:0] wr_flash;
    logic [16:0] port_word;
    logic wr_en;

    always_comb begin
        // Reserved positions read as zero
        control_view = CONTROL_RESET;
        control_view[CTL_TRIG_BIT] = cur_reg.trig;
        control_view[CTL_UNLOCK_BIT] = cur_reg.unlock;
        control_view[CTL_START_BIT] = cur_reg.start;
        control_view[CTL_ADDR_LSB +: CTL_ADDR_W] = cur_reg.cfg_addr;
        image_view = IMAGE_RESET;
        image_view[IMG_VALID_BIT] = cur_reg.valid;
        image_view[IMG_VALUE_W-1:0] = cur_reg.image;
        flash_view = 32'h0000_0000;
        flash_view[FA_READY_BIT] = cur_reg.fready;
        flash_view[FA_CS_BIT] = cur_reg.fcs;
        flash_view[FA_GO_BIT] = cur_reg.fgo;
        flash_view[FA_COUNT_LSB +: 2] = cur_reg.fcount;
        flash_view[FA_DATA_W-1:0] = cur_reg.fdata;
        unique case (wb_adr_i)
            OFS_CONTROL: read_mux = control_view;
            OFS_IMAGE: read_mux = image_view;
            OFS_GOLDEN: read_mux = cur_reg.golden;
            OFS_UPDATE: read_mux = cur_reg.update;
            OFS_FLASH: read_mux = flash_view;
            default: read_mux = 32'h0000_0000;
        endcase
        wr_control = merge_lanes(control_view, wb_dat_i, wb_sel_i);
        wr_flash = merge_lanes(flash_view, wb_dat_i, wb_sel_i);
    end

    // Write lands at the edge where the master sees ack
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && cur_reg.ack;
    assign port_word = seq_word(cur_reg.kind, cur_reg.step, cur_reg.cfg_addr);

    always_comb begin
        cur_next = cur_reg;
        cur_next.ack = wb_cyc_i && wb_stb_i && !cur_reg.ack;
        if (wb_cyc_i && wb_stb_i && !cur_reg.ack) begin
            cur_next.rdata = read_mux;
        end
        cur_next.spi_start = 1'b0;
        cur_next.cap_en = 1'b0;
        cur_next.cap_write = 1'b0;

        // Software writes first, so hardware set events below win
        if (wr_en) begin
            unique case (wb_adr_i)
                OFS_CONTROL: begin
                    cur_next.unlock = wr_control[CTL_UNLOCK_BIT];
                    // Unlock must already be held before this write
                    if (wr_control[CTL_TRIG_BIT] && cur_reg.unlock) begin
                        cur_next.trig = 1'b1;
                    end
                    if (wr_control[CTL_START_BIT]) begin
                        cur_next.start = 1'b1;
                    end
                    cur_next.cfg_addr = wr_control[CTL_ADDR_LSB +: CTL_ADDR_W];
                end
                OFS_GOLDEN: cur_next.golden = merge_lanes(cur_reg.golden, wb_dat_i,
                                                          wb_sel_i);
                OFS_UPDATE: cur_next.update = merge_lanes(cur_reg.update, wb_dat_i,
                                                          wb_sel_i);
                OFS_FLASH: begin
                    cur_next.fdata = wr_flash[FA_DATA_W-1:0];
                    cur_next.fcount = wr_flash[FA_COUNT_LSB +: 2];
                    cur_next.fcs = wr_flash[FA_CS_BIT];
                    if (wr_flash[FA_GO_BIT]) begin
                        cur_next.fgo = 1'b1;
                        cur_next.fready = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        unique case (cur_reg.state)
            SEQ_IDLE: begin
                if (cur_reg.fgo) begin
                    cur_next.fgo = 1'b0;
                    cur_next.byte_idx = 2'h0;
                    cur_next.state = SEQ_TRANSFER_GO_LOAD;
                end else if (cur_reg.start) begin
                    cur_next.valid = 1'b0;
                    cur_next.kind = KIND_RB_PRE;
                    cur_next.step = 3'h0;
                    cur_next.state = SEQ_PORT_WRITE;
                end else if (cur_reg.trig) begin
                    cur_next.trig = 1'b0;
                    cur_next.kind = KIND_PROG;
                    cur_next.step = 3'h0;
                    cur_next.state = SEQ_PORT_WRITE;
                end
            end
            SEQ_TRANSFER_GO_LOAD: begin
                cur_next.spi_start = 1'b1;
                cur_next.state = SEQ_TRANSFER_GO_WAIT;
            end
            SEQ_TRANSFER_GO_WAIT: begin
                if (spi_bus.done) begin
                    cur_next.fdata[8*cur_reg.byte_idx +: 8] = spi_bus.rx_byte;
                    // Reserved count 3 is cut to three bytes
                    if (cur_reg.byte_idx == cur_reg.fcount || cur_reg.byte_idx == 2'h2) begin
                        cur_next.fready = 1'b1;
                        cur_next.state = SEQ_IDLE;
                    end else begin
                        cur_next.byte_idx = cur_reg.byte_idx + 2'h1;
                        cur_next.state = SEQ_TRANSFER_GO_LOAD;
                    end
                end
            end
            SEQ_PORT_WRITE: begin
                cur_next.cap_en = 1'b1;
                cur_next.cap_write = 1'b1;
                cur_next.cap_wdata = port_word[15:0];
                cur_next.step = cur_reg.step + 3'h1;
                if (port_word[16]) begin
                    cur_next.wait_cnt = 3'h0;
                    cur_next.state = (cur_reg.kind == KIND_RB_PRE) ? SEQ_RB_WAIT : SEQ_IDLE;
                end
            end
            SEQ_RB_WAIT: begin
                cur_next.cap_en = 1'b1;
                cur_next.wait_cnt = cur_reg.wait_cnt + 3'h1;
                if (cur_reg.wait_cnt == 3'(READ_WAIT - 1)) begin
                    cur_next.image = cap_rdata[IMG_VALUE_W-1:0];
                    cur_next.valid = 1'b1;
                    cur_next.start = 1'b0;
                    cur_next.kind = KIND_RB_POST;
                    cur_next.step = 3'h0;
                    cur_next.state = SEQ_PORT_WRITE;
                end
            end
            default: cur_next.state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cur_reg <= '0;
            cur_reg.state <= SEQ_IDLE;
            cur_reg.kind <= KIND_RB_PRE;
            cur_reg.golden <= BASE_RESET;
            cur_reg.update <= BASE_RESET;
            cur_reg.fready <= FLASH_RESET[FA_READY_BIT];
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign spi_bus.start = cur_reg.spi_start;
    assign spi_bus.tx_byte = cur_reg.fdata[8*cur_reg.byte_idx +: 8];

    spi_byte_shifter #(
        .HALF_CYC(SCLK_HALF_CYC)
    ) u_shifter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .bus(spi_bus.shifter),
        .flash_sclk(flash_sclk),
        .flash_mosi(flash_mosi),
        .flash_miso(flash_miso)
    );

    // Select bit alone drives the pin; a cleared bit gives a dummy transfer
    assign flash_cs_n = !cur_reg.fcs;
    assign wb_ack_o = cur_reg.ack;
    assign wb_dat_o = cur_reg.rdata;
    assign cap_en = cur_reg.cap_en;
    assign cap_write = cur_reg.cap_write;
    assign cap_wdata = cur_reg.cap_wdata;
endmodule

// [design/reboot_pkg.sv]
/*
 * Shared constants of the reboot flash controller: register offsets,
 * field positions, reset values, timing counts and sequencer states.
 * Assumes a 200 MHz system clock.
 */
package reboot_pkg;

    // Timing
    localparam int unsigned SYS_CLK_PERIOD_NS = 5;
    localparam int unsigned SCLK_HALF_NS = 20;
    localparam int unsigned SCLK_HALF_CYC =
        (SCLK_HALF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned CAP_READ_WAIT_CYC = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_IMAGE = 8'h04;
    localparam logic [7:0] OFS_GOLDEN = 8'h08;
    localparam logic [7:0] OFS_UPDATE = 8'h0C;
    localparam logic [7:0] OFS_FLASH = 8'h10;

    // Control register fields
    localparam int unsigned CTL_TRIG_BIT = 17;
    localparam int unsigned CTL_UNLOCK_BIT = 16;
    localparam int unsigned CTL_START_BIT = 6;
    localparam int unsigned CTL_ADDR_LSB = 0;
    localparam int unsigned CTL_ADDR_W = 6;

    // Image register fields
    localparam int unsigned IMG_VALID_BIT = 16;
    localparam int unsigned IMG_VALUE_W = 16;

    // Flash access register fields
    localparam int unsigned FA_READY_BIT = 28;
    localparam int unsigned FA_CS_BIT = 27;
    localparam int unsigned FA_GO_BIT = 26;
    localparam int unsigned FA_COUNT_LSB = 24;
    localparam int unsigned FA_DATA_W = 24;

    // Reset values
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] IMAGE_RESET = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] FLASH_RESET = 32'h1000_0000;

    typedef enum logic [4:0] {
        SEQ_IDLE = 5'b00001,
        SEQ_TRANSFER_GO_LOAD = 5'b00010,
        SEQ_TRANSFER_GO_WAIT = 5'b00100,
        SEQ_PORT_WRITE = 5'b01000,
        SEQ_RB_WAIT = 5'b10000
    } seq_state_e;

    typedef enum logic [2:0] {
        KIND_RB_PRE = 3'b001,
        KIND_RB_POST = 3'b010,
        KIND_PROG = 3'b100
    } seq_kind_e;

endpackage

// [design/spi_byte_if.sv]
/*
 * Byte handshake between the sequencer and the serial shifter.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface spi_byte_if;
    logic start;
    logic [7:0] tx_byte;
    logic done;
    logic [7:0] rx_byte;

    modport sequencer (output start, output tx_byte, input done, input rx_byte);
    modport shifter (input start, input tx_byte, output done, output rx_byte);
endinterface

// [design/spi_byte_shifter.sv]
/*
 * Mode 0 serial master that moves one byte, MSB first.
 * Assumes start is a one-cycle pulse given only while idle.
 */
`timescale 1ns/1ps
module spi_byte_shifter #(
    parameter int unsigned HALF_CYC = reboot_pkg::SCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Byte handshake
    spi_byte_if.shifter bus,
    // Flash pins
    output logic flash_sclk,
    output logic flash_mosi,
    input wire logic flash_miso
);
    import reboot_pkg::*;

    // Sampling the synchronised input needs two cycles of slack
    if (HALF_CYC < 3) begin : g_half_check
        $error("HALF_CYC must be at least 3");
    end

    typedef struct packed {
        logic busy;
        logic sclk;
        logic mosi;
        logic [7:0] shift;
        logic [2:0] bits;
        logic [7:0] div;
        logic miso_meta;
        logic miso_sync;
        logic done;
        logic [7:0] rx;
    } shifter_s;

    shifter_s cur_reg;
    shifter_s cur_next;

    always_comb begin
        cur_next = cur_reg;
        cur_next.miso_meta = flash_miso;
        cur_next.miso_sync = cur_reg.miso_meta;
        cur_next.done = 1'b0;
        if (!cur_reg.busy) begin
            if (bus.start) begin
                cur_next.busy = 1'b1;
                cur_next.shift = bus.tx_byte;
                cur_next.mosi = bus.tx_byte[7];
                cur_next.bits = 3'h0;
                cur_next.div = 8'h00;
                cur_next.sclk = 1'b0;
            end
        end else if (cur_reg.div == 8'(HALF_CYC - 1)) begin
            cur_next.div = 8'h00;
            if (!cur_reg.sclk) begin
                cur_next.sclk = 1'b1;
            end else begin
                // Late in the high phase the synced sample is settled
                cur_next.shift = {cur_reg.shift[6:0], cur_reg.miso_sync};
                cur_next.sclk = 1'b0;
                if (cur_reg.bits == 3'h7) begin
                    cur_next.busy = 1'b0;
                    cur_next.done = 1'b1;
                    cur_next.rx = {cur_reg.shift[6:0], cur_reg.miso_sync};
                end else begin
                    cur_next.bits = cur_reg.bits + 3'h1;
                    cur_next.mosi = cur_reg.shift[6];
                end
            end
        end else begin
            cur_next.div = cur_reg.div + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign flash_sclk = cur_reg.sclk;
    assign flash_mosi = cur_reg.mosi;
    assign bus.done = cur_reg.done;
    assign bus.rx_byte = cur_reg.rx;
endmodule

// [testbench/reboot_ctrl_assertions.sv]
/* Port checker of the reboot controller.
   Assumes it is bound into reboot_flash_ctrl. */
`timescale 1ns/1ps
module reboot_ctrl_checker #(
    parameter logic [15:0] SYNC_WORD_HI = 16'h1234,
    parameter logic [15:0] HDR_CMD_WRITE = 16'h0005
) (
    // Clock, reset and bus
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Flash and config port
    input wire logic flash_sclk,
    input wire logic flash_mosi,
    input wire logic flash_cs_n,
    input wire logic cap_en,
    input wire logic cap_write,
    input wire logic [15:0] cap_wdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic fa_wr;
    assign fa_wr = wb_ack_o && wb_we_i && wb_adr_i == 8'h10 && wb_sel_i[3];

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h10 |->
        wb_dat_o == 32'h0) else $error("unmapped read not zero");
    reset_pins_a: assert property ($rose(rst_n) |->
        !wb_ack_o && flash_cs_n && !flash_sclk && !cap_en) else $error("bad reset pins");
    cs_follow_a: assert property (fa_wr |=> flash_cs_n == !$past(wb_dat_i[27]))
        else $error("select pin wrong");
    go_start_a: assert property (fa_wr && wb_dat_i[26] |-> ##[2:16] $rose(flash_sclk))
        else $error("transfer not started");
    sclk_high_a: assert property ($rose(flash_sclk) |-> flash_sclk[*4] ##1 !flash_sclk)
        else $error("serial clock high phase wrong");
    mosi_steady_a: assert property (flash_sclk |-> $stable(flash_mosi))
        else $error("data moved while clock high");
    sync_first_a: assert property ($rose(cap_en) |-> cap_write && cap_wdata == SYNC_WORD_HI)
        else $error("sequence not opened by sync");
    read_window_a: assert property ($fell(cap_write) && cap_en |->
        (cap_en && !cap_write)[*4] ##1 (cap_write && cap_wdata == HDR_CMD_WRITE))
        else $error("read window wrong");

    cover property (fa_wr && wb_dat_i[26]);
    cover property ($fell(cap_write) && cap_en);
    cover property ($fell(cap_en));
endmodule

bind reboot_flash_ctrl reboot_ctrl_checker #(.SYNC_WORD_HI(SYNC_WORD_HI),
    .HDR_CMD_WRITE(HDR_CMD_WRITE)) chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .flash_sclk(flash_sclk), .flash_mosi(flash_mosi), .flash_cs_n(flash_cs_n),
    .cap_en(cap_en), .cap_write(cap_write), .cap_wdata(cap_wdata));

// [testbench/far_side_model.sv]
/* Far side: serial flash on the mode 0 link and the config port.
   Assumes the controller drives the link from sys_clk. */
`timescale 1ns/1ps
module far_side_model #(
    parameter int unsigned CAP_W = 16,
    parameter logic [CAP_W-1:0] READ_VAL = '0
) (
    // Clock and flash pins
    input wire logic sys_clk,
    input wire logic flash_sclk,
    input wire logic flash_mosi,
    input wire logic flash_cs_n,
    output logic flash_miso,
    // Config port
    input wire logic cap_en,
    input wire logic cap_write,
    input wire logic [15:0] cap_wdata,
    output logic [CAP_W-1:0] cap_rdata
);
    logic [7:0] rx_sh = 8'h00;
    logic [7:0] reply;
    logic [2:0] bit_n = 3'd0;
    logic [7:0] byte_n = 8'h00;
    logic out_bit = 1'b0;
    logic tgl = 1'b0;
    logic [7:0] rx_q[$];
    logic [15:0] cap_q[$];
    int dummy_edges = 0;
    assign reply = 8'hA0 + byte_n;
    // Released lines toggle so a stale bit never passes
    assign flash_miso = flash_cs_n ? tgl : out_bit;
    assign cap_rdata = (cap_en && !cap_write) ? READ_VAL : {CAP_W{tgl}};
    always @(posedge sys_clk) begin
        tgl <= ~tgl;
        if (cap_en && cap_write) cap_q.push_back(cap_wdata);
    end
    // One process owns the counters; a select rise restarts them
    always @(posedge flash_sclk or posedge flash_cs_n) begin
        if (flash_cs_n) begin
            bit_n = 3'd0;
            byte_n = 8'h00;
            if (flash_sclk) dummy_edges++;
        end else begin
            rx_sh = {rx_sh[6:0], flash_mosi};
            bit_n = bit_n + 3'd1;
            if (bit_n == 3'd0) begin
                rx_q.push_back(rx_sh);
                byte_n = byte_n + 8'h01;
            end
        end
    end
    // First bit is ready at select, later ones after each fall
    always @(negedge flash_sclk or negedge flash_cs_n) out_bit <= reply[3'd7 - bit_n];
endmodule

// [testbench/reboot_flash_ctrl_bench.sv]
/* Self-checking bench of the reboot controller over Wishbone.
   Assumes far_side_model stands at the flash and config port. */
`timescale 1ns/1ps
module reboot_flash_ctrl_bench;
    import reboot_pkg::*;
    localparam logic [15:0] SYNC_HI = 16'h2B4D;
    localparam logic [15:0] HDR_BASE = 16'h0003;
    localparam logic [15:0] REPROG = 16'h0C1F;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, q, fa;
    logic [23:0] rx;
    logic ack, sclk, mosi, cs_n, miso, cap_en, cap_write;
    logic [15:0] cap_wdata;
    logic [19:0] cap_rdata;
    int failures = 0;
    int tests_run = 0;
    always #2.5 sys_clk = ~sys_clk;

    reboot_flash_ctrl #(.SYNC_WORD_HI(SYNC_HI), .HDR_READ_BASE(HDR_BASE), .CMD_REPROG(REPROG),
        .CAP_W(20)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .flash_sclk(sclk), .flash_mosi(mosi), .flash_cs_n(cs_n),
        .flash_miso(miso), .cap_en(cap_en), .cap_write(cap_write), .cap_wdata(cap_wdata),
        .cap_rdata(cap_rdata));
    far_side_model #(.CAP_W(20), .READ_VAL(20'hAE5C3)) model (.sys_clk(sys_clk),
        .flash_sclk(sclk), .flash_mosi(mosi), .flash_cs_n(cs_n), .flash_miso(miso),
        .cap_en(cap_en), .cap_write(cap_write), .cap_wdata(cap_wdata), .cap_rdata(cap_rdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // No fixed latency assumed; waits for ack
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s);
        int n = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) check({31'h0, ack}, 32'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0, 4'h0);
        check(q, exp);
    endtask
    task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
        int n = 0;
        do begin
            bus(a, 1'b0, 32'h0, 4'h0);
            n++;
        end while (q[b] !== v && n < 300);
        check(32'(q[b]), 32'(v));
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk(OFS_CONTROL, 32'h0);
        rdchk(OFS_IMAGE, 32'h0);
        rdchk(OFS_FLASH, 32'h1000_0000);
        bus(8'h14, 1'b1, 32'hFFFF_FFFF, 4'hF);
        rdchk(8'h14, 32'h0);
        bus(OFS_IMAGE, 1'b1, 32'h0001_FFFF, 4'hF);
        rdchk(OFS_IMAGE, 32'h0);
        for (int i = 0; i < 2; i++) begin
            rdchk(OFS_GOLDEN + 8'(4 * i), 32'h0);
            bus(OFS_GOLDEN + 8'(4 * i), 1'b1, 32'hFFFF_FFFF, 4'hF);
            bus(OFS_GOLDEN + 8'(4 * i), 1'b1, 32'h1234_5678, 4'h5);
            rdchk(OFS_GOLDEN + 8'(4 * i), 32'hFF34_FF78);
        end
        // Each length from one to three bytes, select dropped between
        for (int c = 0; c < 3; c++) begin
            model.rx_q.delete();
            bus(OFS_FLASH, 1'b1, 32'h0, 4'hF);
            @(negedge sys_clk);
            check({31'h0, cs_n}, 32'h1);
            fa = 32'h0C96_5A3C | (32'(c) << 24);
            bus(OFS_FLASH, 1'b1, fa, 4'hF);
            @(negedge sys_clk);
            check({31'h0, cs_n}, 32'h0);
            wait_bit(OFS_FLASH, FA_READY_BIT, 1'b1);
            rx = fa[23:0];
            check(32'(model.rx_q.size()), 32'(c + 1));
            for (int k = 0; k <= c; k++) begin
                rx[8 * k +: 8] = 8'hA0 + 8'(k);
                check(32'(model.rx_q[k]), 32'(fa[8 * k +: 8]));
            end
            check(q, {4'h1, 2'b10, 2'(c), rx});
        end
        bus(OFS_FLASH, 1'b1, 32'h0400_0000, 4'hF);
        wait_bit(OFS_FLASH, FA_READY_BIT, 1'b1);
        check(32'(q[31:24]), 32'h10);
        check(32'(model.dummy_edges), 32'd8);
        model.cap_q.delete();
        bus(OFS_CONTROL, 1'b1, 32'h0000_006A, 4'hF);
        wait_bit(OFS_CONTROL, CTL_START_BIT, 1'b0);
        check(q, 32'h0000_002A);
        rdchk(OFS_IMAGE, 32'h0001_E5C3);
        repeat (8) @(posedge sys_clk);
        check(32'(model.cap_q.size()), 32'd10);
        check(32'(model.cap_q[0]), 32'(SYNC_HI));
        check(32'(model.cap_q[3]), 32'(HDR_BASE | (16'h002A << 5)));
        // Trigger without unlock must be dropped
        model.cap_q.delete();
        bus(OFS_CONTROL, 1'b1, 32'h0002_0000, 4'hF);
        repeat (20) @(posedge sys_clk);
        check(32'(model.cap_q.size()), 32'd0);
        bus(OFS_CONTROL, 1'b1, 32'h0001_0000, 4'hF);
        bus(OFS_CONTROL, 1'b1, 32'h0003_0000, 4'hF);
        repeat (20) @(posedge sys_clk);
        check(32'(model.cap_q.size()), 32'd6);
        check(32'(model.cap_q[4]), 32'(REPROG));
        give_verdict();
    end
endmodule
